// ### pkg/cmba_pkg.sv
// constants, region decode and helpers for the cpu memory bus access block
// Notes on behaviour
// [R1] status mirror bits 7..5 return the live cpu interrupt level 0..7
// [R2] status mirror bit 4 returns the live global interrupt enable
// [R3] bits 3..0 return carry, overflow, zero, negative; read only, reset 0
// [R4] debug base returns 64-byte work area start in 23..0; 31..24 read zero
// [R5] one bus access cycle is one system clock period
// [R6] 8-bit target: 1/2/4 cycles; 16-bit: 1/1/2; 32-bit: always one
// [R7] peripheral targets take 8, 16 and 32-bit accesses, split as needed
// [R8] 32-bit store of a 24-bit register writes zero in the top byte
// [R9] 32-bit load keeps only the low 24 bits, top byte dropped
// [R10] interrupt stack word carries status in top byte, return address low
// [R11] every memory and control register answers 16-bit in one cycle
// [R12] fetch stalls for a data access to the same flash or ram area
// [R13] vector table base is 0x8000 after reset
// [R14] flash read cycles follow the 2-bit software wait field
// [R15] software picks a wait setting rated above the system clock
// [R16] application keeps off the last 64 bytes of ram while debugging
// [R17] 3-bit ram size field limits ram; beyond it acts as reserved
// [R18] one 16M byte space shared by fetch and data
// [R19] system control writes are blocked unless protection is released
// [R20] writing the status mirror never changes the cpu status
// [R21] peripheral registers decode in 8K bytes from 0x4000
// [R22] status mirror bits 15..8 read zero and ignore writes
`default_nettype none
package cmba_pkg;
    localparam logic [23:0] RAM_IMPL = 24'h001000;
    localparam logic [23:0] PERI_BASE = 24'h004000;
    localparam logic [23:0] PERI_END = 24'h006000;
    localparam logic [23:0] FLASH_BASE = 24'h008000;
    localparam logic [23:0] FLASH_END = 24'h028000;
    localparam logic [23:0] CORE_BASE = 24'hfffc00;
    localparam logic [23:0] REG_PROTECT = 24'h004000;
    localparam logic [23:0] REG_RAM_SIZE = 24'h004002;
    localparam logic [23:0] REG_VEC_LO = 24'h004004;
    localparam logic [23:0] REG_VEC_HI = 24'h004006;
    localparam logic [23:0] REG_STATUS = 24'h004008;
    localparam logic [23:0] REG_DBG_LO = 24'h00400c;
    localparam logic [23:0] REG_DBG_HI = 24'h00400e;
    localparam logic [23:0] REG_FLASH_WAIT = 24'h0041b0;
    localparam logic [23:0] DBG_AREA_BYTES = 24'h000040;
    localparam logic [23:0] DBG_BASE = RAM_IMPL - DBG_AREA_BYTES;
    localparam logic [23:0] VEC_BASE_RST = 24'h008000;
    localparam logic [15:0] PROTECT_KEY = 16'h0096;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [2:0] RAM_SIZE_RST = 3'h7;
    localparam logic [1:0] FLASH_WAIT_RST = 2'h3;
    localparam int RAM_STEP_LOG = 9;
    localparam logic [1:0] ACC_8 = 2'h0;
    localparam logic [1:0] ACC_16 = 2'h1;
    localparam logic [1:0] ACC_32 = 2'h2;

    typedef enum logic [2:0] {
        RG_RAM, RG_FLASH, RG_PERI, RG_CORE, RG_NONE
    } cmba_region_t;

    // full 24-bit decode, fetch and data share it
    function automatic cmba_region_t region_of(input logic [23:0] a);
        if (a < RAM_IMPL) begin
            return RG_RAM;
        end
        if (a >= PERI_BASE && a < PERI_END) begin
            return RG_PERI;
        end
        if (a >= FLASH_BASE && a < FLASH_END) begin
            return RG_FLASH;
        end
        if (a >= CORE_BASE) begin
            return RG_CORE;
        end
        return RG_NONE;
    endfunction

    // log2 of target width in bytes
    function automatic logic [1:0] dev_log(input cmba_region_t r);
        unique case (r)
            RG_RAM: return 2'h2;
            RG_FLASH, RG_PERI: return 2'h1;
            default: return 2'h0;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### rtl/cmba_bus.sv
// bus access logic: access splitting, fetch arbitration, misc registers
`timescale 1ns/1ps
`default_nettype none
module cmba_bus (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [2:0] cpu_il_i,
    input wire logic cpu_ie_i,
    input wire logic cpu_c_i,
    input wire logic cpu_v_i,
    input wire logic cpu_z_i,
    input wire logic cpu_n_i,
    input wire logic d_req_i,
    input wire logic d_wr_i,
    input wire logic d_stack_i,
    input wire logic [1:0] d_size_i,
    input wire logic [23:0] d_addr_i,
    input wire logic [23:0] d_wdata_i,
    output logic d_busy_o,
    output logic d_done_o,
    output logic [23:0] d_rdata_o,
    output logic [7:0] stack_status_o,
    output logic tgt_req_o,
    output logic tgt_we_o,
    output logic [23:0] tgt_addr_o,
    output logic [31:0] tgt_wdata_o,
    input wire logic [31:0] tgt_rdata_i,
    input wire logic i_req_i,
    input wire logic [23:0] i_addr_i,
    output logic i_busy_o,
    output logic i_done_o,
    output logic [15:0] i_rdata_o,
    output logic ftc_req_o,
    output logic [23:0] ftc_addr_o,
    input wire logic [15:0] ftc_rdata_i,
    output logic [23:0] vector_base_o
);
    typedef enum logic {D_IDLE, D_BEAT} cmba_dstate_t;
    cmba_dstate_t d_state;
    cmba_pkg::cmba_region_t l_rg;
    cmba_pkg::cmba_region_t f_lrg;
    logic [1:0] l_dl;
    logic [2:0] l_last;
    logic [2:0] l_beat;
    logic [1:0] l_wait;
    logic [1:0] wcnt;
    logic l_wr;
    logic l_stack;
    logic [31:0] acc;
    logic [1:0] f_wcnt;
    logic [15:0] status_mirror;
    logic [15:0] protect;
    logic [2:0] ram_size_limit;
    logic [1:0] flash_read_wait_sel;

    ////////////////////////////////////////////////////////////////////////
    // decode
    cmba_pkg::cmba_region_t d_rg;
    cmba_pkg::cmba_region_t f_rg;
    wire [7:0] cur_status = {cpu_il_i, cpu_ie_i, cpu_c_i, cpu_v_i,
        cpu_z_i, cpu_n_i};
    assign d_rg = cmba_pkg::region_of(d_addr_i); // [R18]
    assign f_rg = cmba_pkg::region_of(i_addr_i); // [R18]
    wire [1:0] d_dl = cmba_pkg::dev_log(d_rg);
    wire accept = d_req_i && !d_busy_o;
    // own registers sit in the peripheral window
    wire is_reg = d_rg == cmba_pkg::RG_PERI && (d_addr_i inside {
        cmba_pkg::REG_PROTECT, cmba_pkg::REG_RAM_SIZE,
        cmba_pkg::REG_VEC_LO, cmba_pkg::REG_VEC_HI,
        cmba_pkg::REG_STATUS, cmba_pkg::REG_DBG_LO,
        cmba_pkg::REG_DBG_HI, cmba_pkg::REG_FLASH_WAIT}); // [R21]
    wire [23:0] ram_limit =
        24'({1'b0, ram_size_limit} + 4'h1) << cmba_pkg::RAM_STEP_LOG;
    wire ram_over = d_rg == cmba_pkg::RG_RAM
        && d_addr_i >= ram_limit; // [R17]
    // reserved space answers at once with zero, nothing reaches a target
    wire quick = is_reg || ram_over || d_rg == cmba_pkg::RG_NONE; // [R17]
    wire [1:0] beat_log = d_size_i > d_dl ? d_size_i - d_dl : 2'h0; // [R6]
    wire [2:0] last_idx = 3'((3'h1 << beat_log) - 3'h1); // [R7]
    wire [1:0] wait_ld = (d_rg == cmba_pkg::RG_FLASH && !d_wr_i)
        ? flash_read_wait_sel : 2'h0; // [R14]
    // 24-bit registers: top byte is zero unless this is a stack push
    wire [31:0] word_out = {d_stack_i ? cur_status : 8'h00,
        d_wdata_i}; // [R8] [R10]
    wire released = protect == cmba_pkg::PROTECT_KEY;
    wire reg_wr = accept && d_wr_i && is_reg;
    wire sys_wr = reg_wr && released; // [R19]
    wire [15:0] rd_reg =
        d_addr_i == cmba_pkg::REG_STATUS ? status_mirror :
        d_addr_i == cmba_pkg::REG_RAM_SIZE ? {13'h0000, ram_size_limit} :
        d_addr_i == cmba_pkg::REG_FLASH_WAIT ?
            {14'h0000, flash_read_wait_sel} :
        d_addr_i == cmba_pkg::REG_VEC_LO ? vector_base_o[15:0] :
        d_addr_i == cmba_pkg::REG_VEC_HI ? {8'h00, vector_base_o[23:16]} :
        d_addr_i == cmba_pkg::REG_DBG_LO ? cmba_pkg::DBG_BASE[15:0] :
        d_addr_i == cmba_pkg::REG_DBG_HI ?
            {8'h00, cmba_pkg::DBG_BASE[23:16]} : // [R4]
        d_addr_i == cmba_pkg::REG_PROTECT ? {15'h0000, released} :
        16'h0000;
    // lane handling for the beat in flight
    wire [4:0] beat_sh = 5'({2'b00, l_beat} << (3 + l_dl));
    wire [5:0] dev_bits = 6'(6'h08 << l_dl);
    wire [31:0] rmask = l_dl == 2'h0 ? 32'h000000ff :
        l_dl == 2'h1 ? 32'h0000ffff : 32'hffffffff;
    wire [31:0] next_acc = acc | ((tgt_rdata_i & rmask) << beat_sh);
    wire conflict = d_state == D_BEAT && l_rg == f_lrg
        && (l_rg == cmba_pkg::RG_RAM
        || l_rg == cmba_pkg::RG_FLASH); // [R12]

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            status_mirror <= cmba_pkg::STATUS_RST;
            protect <= 16'h0000;
            ram_size_limit <= cmba_pkg::RAM_SIZE_RST;
            flash_read_wait_sel <= cmba_pkg::FLASH_WAIT_RST;
            vector_base_o <= cmba_pkg::VEC_BASE_RST; // [R13]
        end else begin
            // live copy only; writes here go nowhere
            status_mirror <= {8'h00, cur_status}; // [R1] [R2] [R3] [R20] [R22]
            if (reg_wr && d_addr_i == cmba_pkg::REG_PROTECT) begin
                protect <= d_wdata_i[15:0];
            end
            if (sys_wr && d_addr_i == cmba_pkg::REG_RAM_SIZE) begin
                ram_size_limit <= d_wdata_i[2:0]; // [R19]
            end
            if (sys_wr && d_addr_i == cmba_pkg::REG_FLASH_WAIT) begin
                flash_read_wait_sel <= d_wdata_i[1:0]; // [R19]
            end
            if (sys_wr && d_addr_i == cmba_pkg::REG_VEC_LO) begin
                vector_base_o[15:0] <= d_wdata_i[15:0];
            end
            if (sys_wr && d_addr_i == cmba_pkg::REG_VEC_HI) begin
                vector_base_o[23:16] <= d_wdata_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data side: one beat per clock plus flash read waits
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            d_state <= D_IDLE;
            d_busy_o <= 1'b0;
            d_done_o <= 1'b0;
            d_rdata_o <= 24'h000000;
            stack_status_o <= 8'h00;
            tgt_req_o <= 1'b0;
            tgt_we_o <= 1'b0;
            tgt_addr_o <= 24'h000000;
            tgt_wdata_o <= 32'h00000000;
            l_rg <= cmba_pkg::RG_NONE;
            l_dl <= 2'h0;
            l_last <= 3'h0;
            l_beat <= 3'h0;
            l_wait <= 2'h0;
            wcnt <= 2'h0;
            l_wr <= 1'b0;
            l_stack <= 1'b0;
            acc <= 32'h00000000;
        end else begin
            d_done_o <= 1'b0;
            unique case (d_state)
                D_IDLE: begin
                    if (accept && quick) begin
                        d_done_o <= 1'b1; // [R11]
                        d_rdata_o <= is_reg ? {8'h00, rd_reg} : 24'h000000;
                        stack_status_o <= 8'h00;
                    end else if (accept) begin
                        d_state <= D_BEAT;
                        d_busy_o <= 1'b1;
                        tgt_req_o <= 1'b1; // [R5]
                        tgt_we_o <= d_wr_i;
                        tgt_addr_o <= d_addr_i;
                        tgt_wdata_o <= word_out; // [R8]
                        l_rg <= d_rg;
                        l_dl <= d_dl;
                        l_last <= last_idx; // [R6]
                        l_beat <= 3'h0;
                        l_wait <= wait_ld;
                        wcnt <= wait_ld; // [R14]
                        l_wr <= d_wr_i;
                        l_stack <= d_stack_i;
                        acc <= 32'h00000000;
                    end
                end
                D_BEAT: begin
                    if (wcnt != 2'h0) begin
                        wcnt <= wcnt - 2'h1; // [R14]
                    end else if (l_beat == l_last) begin
                        d_state <= D_IDLE;
                        d_busy_o <= 1'b0;
                        d_done_o <= 1'b1;
                        tgt_req_o <= 1'b0;
                        tgt_we_o <= 1'b0;
                        d_rdata_o <= next_acc[23:0]; // [R9]
                        stack_status_o <= l_stack && !l_wr
                            ? next_acc[31:24] : 8'h00; // [R10]
                    end else begin
                        l_beat <= l_beat + 3'h1; // [R7]
                        tgt_addr_o <= 24'(tgt_addr_o + (24'h1 << l_dl));
                        tgt_wdata_o <= tgt_wdata_o >> dev_bits;
                        wcnt <= l_wait;
                        acc <= next_acc;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch side runs in parallel unless it meets the data access
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            i_busy_o <= 1'b0;
            i_done_o <= 1'b0;
            i_rdata_o <= 16'h0000;
            ftc_req_o <= 1'b0;
            ftc_addr_o <= 24'h000000;
            f_lrg <= cmba_pkg::RG_NONE;
            f_wcnt <= 2'h0;
        end else begin
            i_done_o <= 1'b0;
            if (!i_busy_o && i_req_i) begin
                i_busy_o <= 1'b1;
                ftc_req_o <= 1'b1;
                ftc_addr_o <= i_addr_i;
                f_lrg <= f_rg;
                f_wcnt <= f_rg == cmba_pkg::RG_FLASH
                    ? flash_read_wait_sel : 2'h0; // [R14]
            end else if (i_busy_o && !conflict) begin // [R12]
                if (f_wcnt != 2'h0) begin
                    f_wcnt <= f_wcnt - 2'h1;
                end else begin
                    i_busy_o <= 1'b0;
                    ftc_req_o <= 1'b0;
                    i_done_o <= 1'b1;
                    i_rdata_o <= ftc_rdata_i;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks; the counter below exists only for them
    logic [4:0] busy_cnt;
    logic [4:0] lat_expect;
    always_ff @(posedge clock_i) begin
        if (rst_i || accept) begin
            busy_cnt <= 5'h00;
        end else if (d_busy_o) begin
            busy_cnt <= busy_cnt + 5'h01;
        end
    end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lat_expect <= 5'h00;
        end else if (accept) begin
            lat_expect <= 5'(({2'b00, last_idx} + 5'h01)
                * ({3'b000, wait_ld} + 5'h01));
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_mirror_level: assert property (!$past(rst_i) |->
        status_mirror[7:5] == $past(cpu_il_i)) // [R1]
        else $error("mirror interrupt level wrong");
    a_mirror_enable: assert property (!$past(rst_i) |->
        status_mirror[4] == $past(cpu_ie_i)) // [R2]
        else $error("mirror interrupt enable wrong");
    a_mirror_flags: assert property (!$past(rst_i) |->
        status_mirror[3:0] == {$past(cpu_c_i), $past(cpu_v_i),
        $past(cpu_z_i), $past(cpu_n_i)}) // [R3]
        else $error("mirror flags wrong");
    a_dbg_upper_zero: assert property (accept && !d_wr_i
        && d_addr_i == cmba_pkg::REG_DBG_HI |=> d_done_o
        && d_rdata_o == {16'h0000, cmba_pkg::DBG_BASE[23:16]}) // [R4]
        else $error("debug base high half wrong");
    a_beat_count: assert property (d_done_o && $past(d_busy_o) |->
        busy_cnt == lat_expect) // [R6]
        else $error("bus cycle count wrong");
    a_byte_four: assert property (accept && !quick
        && d_size_i == cmba_pkg::ACC_32 && d_rg == cmba_pkg::RG_CORE
        |=> d_busy_o [*4] ##1 (d_done_o && !d_busy_o)) // [R6]
        else $error("8-bit target 32-bit access not four cycles");
    a_flash_wait: assert property (accept && !d_wr_i
        && d_rg == cmba_pkg::RG_FLASH && d_size_i == cmba_pkg::ACC_16
        && flash_read_wait_sel == 2'h3
        |=> tgt_req_o [*4] ##1 d_done_o) // [R14]
        else $error("flash read wait not applied");
    a_store_top_zero: assert property (d_state == D_BEAT && l_wr
        && !l_stack && l_beat == 3'h0 |-> tgt_wdata_o[31:24] == 8'h00) // [R8]
        else $error("store top byte not zero");
    a_load_low24: assert property (d_done_o
        && $past(d_state == D_BEAT && l_rg == cmba_pkg::RG_RAM && !l_wr)
        |-> d_rdata_o == $past(tgt_rdata_i[23:0])) // [R9]
        else $error("load data not low 24 bits");
    a_stack_status: assert property (accept && !quick && d_wr_i
        && d_stack_i |=> tgt_wdata_o[31:24] == $past(cur_status)) // [R10]
        else $error("stack word status byte wrong");
    a_reg_one_cycle: assert property (accept && is_reg
        |=> d_done_o && !d_busy_o && !tgt_req_o) // [R11]
        else $error("register access not one cycle");
    a_fetch_stall: assert property (i_busy_o && conflict
        |=> i_busy_o && !i_done_o) // [R12]
        else $error("fetch ran during conflicting data access");
    a_vec_reset: assert property ($past(rst_i)
        |-> vector_base_o == cmba_pkg::VEC_BASE_RST) // [R13]
        else $error("vector base reset value wrong");
    a_ram_limit: assert property (accept && ram_over
        |=> !tgt_req_o && d_done_o && d_rdata_o == 24'h000000) // [R17]
        else $error("access beyond ram limit reached target");
    a_protect_hold: assert property (accept && d_wr_i && !released
        && d_addr_i == cmba_pkg::REG_RAM_SIZE
        |=> $stable(ram_size_limit)) // [R19]
        else $error("protected register changed");

    c_byte_split: cover property (accept && d_rg == cmba_pkg::RG_CORE
        && d_size_i == cmba_pkg::ACC_32);
    c_fetch_stall: cover property (i_busy_o && conflict);
    c_stack_push: cover property (accept && d_wr_i && d_stack_i);
    c_flash_wait: cover property (d_state == D_BEAT && wcnt != 2'h0);
endmodule
`default_nettype wire

// ### dv/cmba_tgt_model.sv
// target memory model answering the data and fetch target ports
`timescale 1ns/1ps
`default_nettype none
module cmba_tgt_model (
    input wire logic clock_i,
    input wire logic tgt_req_i,
    input wire logic tgt_we_i,
    input wire logic [23:0] tgt_addr_i,
    input wire logic [31:0] tgt_wdata_i,
    output logic [31:0] tgt_rdata_o,
    input wire logic ftc_req_i,
    input wire logic [23:0] ftc_addr_i,
    output logic [15:0] ftc_rdata_o
);
    // only low 12 address bits kept, bench keeps its test areas apart
    logic [7:0] mem [0:4095];
    logic [31:0] junk = 32'h0;
    logic [11:0] ta;
    logic [11:0] fa;
    int wb;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
        end
    end
    ////////////////////////////////////////////////////////////////////
    assign ta = tgt_addr_i[11:0];
    assign fa = ftc_addr_i[11:0];
    // idle lines change every cycle so stale data never looks valid
    always @(tgt_req_i or ta or fa or ftc_req_i or junk) begin
        tgt_rdata_o = junk;
        ftc_rdata_o = ~junk[15:0];
        if (tgt_req_i) begin
            tgt_rdata_o = {mem[ta + 12'h3], mem[ta + 12'h2],
                mem[ta + 12'h1], mem[ta]};
        end
        if (ftc_req_i) begin
            ftc_rdata_o = {mem[fa + 12'h1], mem[fa]};
        end
    end
    ////////////////////////////////////////////////////////////////////
    always @(posedge clock_i) begin
        junk <= junk + 32'h9e3779b9;
        if (tgt_req_i && tgt_we_i) begin
            wb = tgt_addr_i < 24'h001000 ? 4 :
                (tgt_addr_i >= 24'hfffc00 ? 1 : 2);
            for (int k = 0; k < wb; k++) begin
                mem[ta + 12'(k)] <= tgt_wdata_i[k*8 +: 8];
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/cmba_bus_bench.sv
// self-checking bench for the cpu memory bus access block
`timescale 1ns/1ps
`default_nettype none
module cmba_bus_bench;
    localparam logic [1:0] S16 = cmba_pkg::ACC_16;
    localparam logic [1:0] S32 = cmba_pkg::ACC_32;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] cpu_il_i = 3'h0;
    logic [4:0] flg = 5'h00;
    logic d_req_i = 1'b0;
    logic d_wr_i = 1'b0;
    logic d_stack_i = 1'b0;
    logic [1:0] d_size_i = 2'h0;
    logic [23:0] d_addr_i = 24'h0;
    logic [23:0] d_wdata_i = 24'h0;
    logic i_req_i = 1'b0;
    logic [23:0] i_addr_i = 24'h0;
    logic d_busy_o, d_done_o, tgt_req_o, tgt_we_o, i_busy_o, i_done_o;
    logic ftc_req_o;
    logic [23:0] d_rdata_o, tgt_addr_o, ftc_addr_o, vector_base_o;
    logic [7:0] stack_status_o;
    logic [31:0] tgt_wdata_o, tgt_rdata_i;
    logic [15:0] i_rdata_o, ftc_rdata_i;
    logic [23:0] rd;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    int nf;
    cmba_bus dut (.clock_i(clock_i), .rst_i(rst_i), .cpu_il_i(cpu_il_i),
        .cpu_ie_i(flg[4]), .cpu_c_i(flg[3]), .cpu_v_i(flg[2]),
        .cpu_z_i(flg[1]), .cpu_n_i(flg[0]), .d_req_i(d_req_i),
        .d_wr_i(d_wr_i), .d_stack_i(d_stack_i), .d_size_i(d_size_i),
        .d_addr_i(d_addr_i), .d_wdata_i(d_wdata_i), .d_busy_o(d_busy_o),
        .d_done_o(d_done_o), .d_rdata_o(d_rdata_o),
        .stack_status_o(stack_status_o), .tgt_req_o(tgt_req_o),
        .tgt_we_o(tgt_we_o), .tgt_addr_o(tgt_addr_o),
        .tgt_wdata_o(tgt_wdata_o), .tgt_rdata_i(tgt_rdata_i),
        .i_req_i(i_req_i), .i_addr_i(i_addr_i), .i_busy_o(i_busy_o),
        .i_done_o(i_done_o), .i_rdata_o(i_rdata_o), .ftc_req_o(ftc_req_o),
        .ftc_addr_o(ftc_addr_o), .ftc_rdata_i(ftc_rdata_i),
        .vector_base_o(vector_base_o));
    cmba_tgt_model m (.clock_i(clock_i), .tgt_req_i(tgt_req_o),
        .tgt_we_i(tgt_we_o), .tgt_addr_i(tgt_addr_o),
        .tgt_wdata_i(tgt_wdata_o), .tgt_rdata_o(tgt_rdata_i),
        .ftc_req_i(ftc_req_o), .ftc_addr_i(ftc_addr_o),
        .ftc_rdata_o(ftc_rdata_i));
    always #20 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction
    task automatic check(input string what, input logic [23:0] seen,
        input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held up to the taking edge, n counts edges to done
    task automatic acc(input logic wr, input logic stk,
        input logic [1:0] sz, input logic [23:0] a, input logic [23:0] wd);
        @(posedge clock_i);
        d_req_i <= 1'b1;
        d_wr_i <= wr;
        d_stack_i <= stk;
        d_size_i <= sz;
        d_addr_i <= a;
        d_wdata_i <= wd;
        @(posedge clock_i);
        d_req_i <= 1'b0;
        n = 0;
        // read at the edge before it updates: done stands one cycle only
        do begin
            @(posedge clock_i);
            n++;
        end while (d_done_o !== 1'b1 && n < 40);
        rd = d_rdata_o;
    endtask
    task automatic fetch(input logic [23:0] a);
        @(posedge clock_i);
        i_req_i <= 1'b1;
        i_addr_i <= a;
        @(posedge clock_i);
        i_req_i <= 1'b0;
        nf = 0;
        do begin
            @(posedge clock_i);
            nf++;
        end while (i_done_o !== 1'b1 && nf < 40);
    endtask
    task automatic rr(input logic [23:0] a);
        acc(1'b0, 1'b0, S16, a, 24'h0);
    endtask
    task automatic wr(input logic [23:0] a, input logic [23:0] d);
        acc(1'b1, 1'b0, S16, a, d);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        check("vector out", vector_base_o, 24'h008000);
        rr(cmba_pkg::REG_VEC_LO);
        check("vector reg", rd, 24'h008000);
        rr(cmba_pkg::REG_STATUS);
        check("mirror reset", rd, 24'h0);
        check("reg cycles", 24'(n), 24'h1);
        for (int i = 0; i < 8; i++) begin
            cpu_il_i <= 3'(i);
            flg <= 5'(i * 5 + 3);
            wr(cmba_pkg::REG_STATUS, 24'h00ffff);
            rr(cmba_pkg::REG_STATUS);
            check("mirror", rd, {16'h0, 3'(i), 5'(i * 5 + 3)});
        end
        wr(cmba_pkg::REG_DBG_LO, 24'h001234);
        rr(cmba_pkg::REG_DBG_LO);
        check("dbg lo", rd, 24'h000fc0);
        rr(cmba_pkg::REG_DBG_HI);
        check("dbg hi", rd, 24'h0);
        wr(cmba_pkg::REG_FLASH_WAIT, 24'h0);
        rr(cmba_pkg::REG_FLASH_WAIT);
        check("wait locked", rd, 24'h3);
        wr(cmba_pkg::REG_RAM_SIZE, 24'h0);
        rr(cmba_pkg::REG_RAM_SIZE);
        check("size locked", rd, 24'h7);
        wr(cmba_pkg::REG_PROTECT, 24'h000096);
        rr(cmba_pkg::REG_PROTECT);
        check("protect open", rd, 24'h1);
        for (int w = 0; w < 4; w++) begin
            wr(cmba_pkg::REG_FLASH_WAIT, 24'(w));
            acc(1'b0, 1'b0, S32, 24'h008010, 24'h0);
            check("flash cycles", 24'(n), 24'(2 * (1 + w) + 1));
            check("flash data", rd, {pat(24'h12), pat(24'h11), pat(24'h10)});
            acc(1'b0, 1'b0, S16, 24'h008010, 24'h0);
            check("flash half cycles", 24'(n), 24'(w + 2));
            check("flash half", rd, {8'h0, pat(24'h11), pat(24'h10)});
        end
        for (int s = 0; s < 3; s++) begin
            acc(1'b0, 1'b0, 2'(s), 24'h000100, 24'h0);
            check("ram cycles", 24'(n), 24'h2);
            acc(1'b0, 1'b0, 2'(s), 24'h004100, 24'h0);
            check("peri cycles", 24'(n), 24'(s / 2 + 2));
            acc(1'b0, 1'b0, 2'(s), 24'hfffc20, 24'h0);
            check("core cycles", 24'(n), 24'((1 << s) + 1));
        end
        check("core data", rd, {pat(24'h22), pat(24'h21), pat(24'h20)});
        acc(1'b1, 1'b0, S32, 24'hfffc40, 24'ha1b2c3);
        check("core split", {m.mem[12'hc42], m.mem[12'hc41], m.mem[12'hc40]}, 24'ha1b2c3);
        check("core top", {16'h0, m.mem[12'hc43]}, 24'h0);
        acc(1'b1, 1'b0, S32, 24'h000200, 24'habcdef);
        check("store top", {16'h0, m.mem[12'h203]}, 24'h0);
        acc(1'b0, 1'b0, S32, 24'h000200, 24'h0);
        check("load", rd, 24'habcdef);
        check("load status", {16'h0, stack_status_o}, 24'h0);
        cpu_il_i <= 3'h6;
        flg <= 5'h15;
        acc(1'b1, 1'b1, S32, 24'h000204, 24'h123456);
        check("stack top", {16'h0, m.mem[12'h207]}, 24'h0000d5);
        acc(1'b0, 1'b1, S32, 24'h000204, 24'h0);
        check("stack addr", rd, 24'h123456);
        check("stack status", {16'h0, stack_status_o}, 24'h0000d5);
        wr(cmba_pkg::REG_FLASH_WAIT, 24'h0);
        fork
            acc(1'b0, 1'b0, S32, 24'h008020, 24'h0);
            fetch(24'h008030);
        join
        check("fetch stall", 24'(nf), 24'h4);
        check("fetch data", {8'h0, i_rdata_o}, {8'h0, pat(24'h31), pat(24'h30)});
        fork
            acc(1'b0, 1'b0, S32, 24'h008020, 24'h0);
            fetch(24'h000300);
        join
        check("fetch parallel", 24'(nf), 24'h2);
        // test addresses stay below the debugger's ram tail
        wr(cmba_pkg::REG_RAM_SIZE, 24'h0);
        rr(24'h0001fe);
        check("ram in limit", 24'(n), 24'h2);
        rr(24'h000200);
        check("ram beyond", rd, 24'h0);
        check("ram beyond cycles", 24'(n), 24'h1);
        rr(24'h005ffe);
        check("peri end", 24'(n), 24'h2);
        rr(24'h006000);
        check("unmapped", 24'(n), 24'h1);
        check("unmapped data", rd, 24'h0);
        wr(cmba_pkg::REG_PROTECT, 24'h0);
        wr(cmba_pkg::REG_VEC_LO, 24'h001234);
        rr(cmba_pkg::REG_VEC_LO);
        check("vector locked", rd, 24'h008000);
        stop_test();
    end
endmodule
`default_nettype wire
